// File: rtl/bank_remap.v
// Flash bank to RAM block remapper with its select registers and access router
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "remap_regs.vh"

module bank_remap #(
  parameter FULL_VARIANT = 1,
  parameter EXCLUDE_UPPER = 0
) (
  input wire clk,
  input wire rst_b,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire cpu_req,
  input wire cpu_we,
  input wire [31:0] cpu_addr,
  input wire [31:0] cpu_wdata,
  output reg flash_req,
  output reg ram_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  output reg remapped
);

  localparam LARGE_COUNT = FULL_VARIANT ? `LARGE_COUNT_FULL : `LARGE_COUNT_REDUCED;
  localparam [31:0] RAM_END = FULL_VARIANT ? `RAM_END_FULL : `RAM_END_REDUCED;

  // Software visible state
  reg mode_r;
  reg [6:0] large_field_r [0:3];
  reg [3:0] large_en_r;
  reg [7:0] small_field_r [0:1];
  reg [1:0] small_en_r;
  reg [15:0] hit_count_r;
  reg [15:0] hit_count_nxt;
  reg last_hit_r;
  reg [2:0] last_sel_r;
  reg [15:0] rdata_nxt;

  // Match results for the current CPU access
  wire hit;
  wire [2:0] sel;
  wire [31:0] target;
  wire in_flash;
  wire in_ram;
  wire [27:0] large_fields;
  wire [15:0] small_fields;

  integer k;

  assign large_fields = {large_field_r[3], large_field_r[2], large_field_r[1], large_field_r[0]};
  assign small_fields = {small_field_r[1], small_field_r[0]};
  assign in_flash = (cpu_addr[31:20] == `FLASH_SPACE_TOP);
  assign in_ram = (cpu_addr >= `RAM_BASE) && (cpu_addr <= RAM_END);

  // Comparator sees the live registers; software's settle time covers the path
  remap_match #(
    .FULL_VARIANT(FULL_VARIANT),
    .EXCLUDE_UPPER(EXCLUDE_UPPER)
  ) u_match (
    .addr(cpu_addr),
    .mode(mode_r),
    .large_fields(large_fields),
    .large_en(large_en_r),
    .small_fields(small_fields),
    .small_en(small_en_r),
    .hit(hit),
    .sel(sel),
    .target(target)
  );

  // Register writes; a select written for an absent large bank is dropped
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= 1'b0;
      large_en_r <= 4'h0;
      small_en_r <= 2'h0;
      for (k = 0; k < 4; k = k + 1) begin
        large_field_r[k] <= `LARGE_FIELD_RESET;
      end
      for (k = 0; k < 2; k = k + 1) begin
        small_field_r[k] <= `SMALL_FIELD_RESET;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_FLASH_CONTROL_ONE: begin
          mode_r <= reg_wdata[`MODE_BIT_POS];
        end
        `REG_LARGE_SELECT_0, `REG_LARGE_SELECT_1, `REG_LARGE_SELECT_2,
        `REG_LARGE_SELECT_3: begin
          for (k = 0; k < 4; k = k + 1) begin
            if ((k < LARGE_COUNT) && (reg_addr == `REG_LARGE_SELECT_0 + k[3:0])) begin
              large_field_r[k] <= reg_wdata[6:0];
              large_en_r[k] <= reg_wdata[`BANK_ENABLE_POS];
            end
          end
        end
        `REG_SMALL_SELECT_0: begin
          small_field_r[0] <= reg_wdata[7:0];
          small_en_r[0] <= reg_wdata[`BANK_ENABLE_POS];
        end
        `REG_SMALL_SELECT_1: begin
          small_field_r[1] <= reg_wdata[7:0];
          small_en_r[1] <= reg_wdata[`BANK_ENABLE_POS];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets and absent banks read as zero
  always @* begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      `REG_FLASH_CONTROL_ONE: rdata_nxt[`MODE_BIT_POS] = mode_r;
      `REG_LARGE_SELECT_0: rdata_nxt = {large_en_r[0], 8'h00, large_field_r[0]};
      `REG_LARGE_SELECT_1: rdata_nxt = {large_en_r[1], 8'h00, large_field_r[1]};
      `REG_LARGE_SELECT_2: rdata_nxt = {large_en_r[2], 8'h00, large_field_r[2]};
      `REG_LARGE_SELECT_3: rdata_nxt = {large_en_r[3], 8'h00, large_field_r[3]};
      `REG_SMALL_SELECT_0: rdata_nxt = {small_en_r[0], 7'h00, small_field_r[0]};
      `REG_SMALL_SELECT_1: rdata_nxt = {small_en_r[1], 7'h00, small_field_r[1]};
      `REG_ROUTE_STATUS: rdata_nxt = {12'h000, last_hit_r, last_sel_r};
      `REG_HIT_COUNT: rdata_nxt = hit_count_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Hit counter; a remapped access in the clearing cycle still counts
  always @* begin
    hit_count_nxt = hit_count_r;
    if (reg_wr && reg_addr == `REG_HIT_COUNT) begin
      hit_count_nxt = `HIT_COUNT_RESET;
    end
    if (cpu_req && hit && hit_count_nxt != 16'hFFFF) begin
      hit_count_nxt = hit_count_nxt + 16'h0001;
    end
  end

  // Status of the last flash-space access, held until the next one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_count_r <= `HIT_COUNT_RESET;
      last_hit_r <= 1'b0;
      last_sel_r <= 3'h0;
    end else begin
      hit_count_r <= hit_count_nxt;
      if (cpu_req && in_flash) begin
        last_hit_r <= hit;
        last_sel_r <= sel;
      end
    end
  end

  // Access router: one register stage so every output leaves a flip-flop
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_req <= 1'b0;
      ram_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      remapped <= 1'b0;
    end else begin
      flash_req <= 1'b0;
      ram_req <= 1'b0;
      remapped <= 1'b0;
      if (cpu_req) begin
        mem_we <= cpu_we;
        mem_wdata <= cpu_wdata;
        if (in_flash && hit) begin
          ram_req <= 1'b1;
          remapped <= 1'b1;
          mem_addr <= target;
        end else if (in_flash) begin
          flash_req <= 1'b1;
          mem_addr <= cpu_addr;
        end else if (in_ram) begin
          ram_req <= 1'b1;
          mem_addr <= cpu_addr;
        end else begin
          mem_addr <= cpu_addr;
        end
      end else begin
        mem_we <= 1'b0;
      end
    end
  end

endmodule // bank_remap

// File: rtl/remap_regs.vh
// Register offsets, field positions, reset values and address map of the bank remapper
`ifndef REMAP_REGS_VH
`define REMAP_REGS_VH

// Register indices on the plain register port
`define REG_FLASH_CONTROL_ONE 4'h0
`define REG_LARGE_SELECT_0 4'h1
`define REG_LARGE_SELECT_1 4'h2
`define REG_LARGE_SELECT_2 4'h3
`define REG_LARGE_SELECT_3 4'h4
`define REG_SMALL_SELECT_0 4'h5
`define REG_SMALL_SELECT_1 4'h6
`define REG_ROUTE_STATUS 4'h7
`define REG_HIT_COUNT 4'h8

// Field positions
`define MODE_BIT_POS 0
`define BANK_ENABLE_POS 15
`define LARGE_FIELD_W 7
`define SMALL_FIELD_W 8

// Reset values
`define CONTROL_RESET 16'h0000
`define SELECT_RESET 16'h0000
`define LARGE_FIELD_RESET 7'h00
`define SMALL_FIELD_RESET 8'h00
`define HIT_COUNT_RESET 16'h0000

// Address map
`define FLASH_SPACE_TOP 12'h000
`define RAM_BASE 32'h00804000
`define RAM_END_FULL 32'h0080DFFF
`define RAM_END_REDUCED 32'h0080BFFF
`define SMALL_BASE_FULL 32'h0080C000
`define SMALL_BASE_REDUCED 32'h0080A000
`define LARGE_BLOCK_SIZE 32'h00002000
`define SMALL_BLOCK_SIZE 32'h00001000
`define EXCLUDED_LO 32'h0080C000
`define EXCLUDED_HI 32'h0080DFFF

// Bank counts
`define LARGE_COUNT_FULL 4
`define LARGE_COUNT_REDUCED 3

`endif

// File: rtl/remap_match.v
// Combinational bank comparator and priority selector for the remapper
`timescale 1ns/1ps
`include "remap_regs.vh"

module remap_match #(
  parameter FULL_VARIANT = 1,
  parameter EXCLUDE_UPPER = 0
) (
  input wire [31:0] addr,
  input wire mode,
  input wire [27:0] large_fields,
  input wire [3:0] large_en,
  input wire [15:0] small_fields,
  input wire [1:0] small_en,
  output reg hit,
  output reg [2:0] sel,
  output reg [31:0] target
);

  localparam LARGE_COUNT = FULL_VARIANT ? `LARGE_COUNT_FULL : `LARGE_COUNT_REDUCED;
  localparam [31:0] SMALL_BASE = FULL_VARIANT ? `SMALL_BASE_FULL : `SMALL_BASE_REDUCED;

  // Large bank: field holds A12-A18, the A12 bit is ignored for 8 Kbyte banks
  function large_hit;
    input [31:0] a;
    input [6:0] field;
    begin
      large_hit = (a[19] == 1'b0) && (a[18:13] == field[6:1]);
    end
  endfunction

  // Small bank: field holds A12-A19
  function small_hit;
    input [31:0] a;
    input [7:0] field;
    begin
      small_hit = (a[19:12] == field);
    end
  endfunction

  integer i;
  reg in_flash;

  // Lowest priority tested first so that the highest priority match is the last to land
  always @* begin
    in_flash = (addr[31:20] == `FLASH_SPACE_TOP);
    hit = 1'b0;
    sel = 3'h0;
    target = addr;
    if (in_flash && mode) begin
      for (i = 1; i >= 0; i = i - 1) begin
        if (small_en[i] && small_hit(addr, small_fields[i*8 +: 8])) begin
          hit = 1'b1;
          sel = 3'h4 + i[2:0];
          target = SMALL_BASE + (`SMALL_BLOCK_SIZE * i) + {20'h00000, addr[11:0]};
        end
      end
      for (i = 3; i >= 0; i = i - 1) begin
        if ((i < LARGE_COUNT) && large_en[i] &&
            large_hit(addr, large_fields[i*7 +: 7])) begin
          hit = 1'b1;
          sel = i[2:0];
          target = `RAM_BASE + (`LARGE_BLOCK_SIZE * i) + {19'h00000, addr[12:0]};
        end
      end
      // Reserved RAM range never stands in for flash; the access falls back to flash
      if (hit && EXCLUDE_UPPER && target >= `EXCLUDED_LO && target <= `EXCLUDED_HI) begin
        hit = 1'b0;
        sel = 3'h0;
        target = addr;
      end
    end
  end

endmodule // remap_match

// File: sim/bank_remap_monitor.sv
// Port checker for the bank remapper
`timescale 1ns/1ps
module bank_remap_monitor (
  input wire clk,
  input wire rst_b,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire cpu_req,
  input wire cpu_we,
  input wire [31:0] cpu_addr,
  input wire [31:0] cpu_wdata,
  input wire flash_req,
  input wire ram_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire remapped
);
  // All checks share the one clock and its reset
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_ANSWER_AFTER_REQ:
    assert property ((flash_req || ram_req) |-> $past(cpu_req)) else $error("Stray route pulse");
  AST_FLASH_SPACE_ROUTED:
    assert property (cpu_req && cpu_addr[31:20] == 12'h000 |=> flash_req ^ ram_req)
      else $error("Flash access not routed once");
  AST_DIRECT_RAM:
    assert property (cpu_req && cpu_addr >= 32'h00804000 && cpu_addr <= 32'h0080BFFF
      |=> ram_req && !remapped && mem_addr == $past(cpu_addr)) else $error("RAM access misrouted");
  AST_REMAP_IN_RAM:
    assert property (remapped |-> ram_req && mem_addr >= 32'h00804000 && mem_addr <= 32'h0080DFFF)
      else $error("Remap target outside RAM");
  AST_REMAP_OFFSET:
    assert property (remapped |-> ((mem_addr ^ $past(cpu_addr)) & 32'h00000FFF) == 32'h0)
      else $error("Remap offset lost");
  AST_COPY_WRITE:
    assert property ((flash_req || ram_req) |-> mem_wdata == $past(cpu_wdata)
      && mem_we == $past(cpu_we)) else $error("Write data or direction lost");
  AST_FLASH_ADDR:
    assert property (flash_req |-> !remapped && mem_addr == $past(cpu_addr))
      else $error("Flash address altered");
  AST_RDATA_ZERO:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("Read data not zero");
  // Main traffic kinds
  cover property (remapped && mem_we);
  cover property (flash_req);
  cover property (ram_req && !remapped);
endmodule // bank_remap_monitor

bind bank_remap bank_remap_monitor u_bank_remap_monitor (.clk, .rst_b, .reg_rd, .reg_rdata,
  .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .flash_req, .ram_req, .mem_we, .mem_addr,
  .mem_wdata, .remapped);

// File: sim/cpu_core_model.sv
// CPU core model issuing single bus accesses
`timescale 1ns/1ps
module cpu_core_model (
  input wire clk,
  output reg cpu_req,
  output reg cpu_we,
  output reg [31:0] cpu_addr,
  output reg [31:0] cpu_wdata
);
  // Idle bus at time zero
  initial begin
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = 32'h00000000;
    cpu_wdata = 32'h00000000;
  end
  // Three idle clocks first keep the settling wait after register writes;
  // the model never issues flash programming commands
  task issue(input logic we, input logic [31:0] a, input logic [31:0] d);
    begin
      repeat (3) @(posedge clk);
      cpu_req <= 1'b1;
      cpu_we <= we;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge clk);
      cpu_req <= 1'b0;
      cpu_we <= 1'b0;
      cpu_addr <= ~a; // Released bus must not show a stale address
      cpu_wdata <= ~d;
    end
  endtask
endmodule // cpu_core_model

// File: sim/bank_remap_bench.sv
// Self-checking bench for the bank remapper
`timescale 1ns/1ps
module bank_remap_bench;
  localparam [2:0] FL = 3'h4;
  localparam [2:0] RD = 3'h2;
  localparam [2:0] RM = 3'h3;
  logic clk, rst_b, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  wire [15:0] reg_rdata;
  wire cpu_req, cpu_we, flash_req, ram_req, mem_we, remapped;
  wire [31:0] cpu_addr, cpu_wdata, mem_addr, mem_wdata;
  integer miscompares = 0;
  integer checks = 0;
  integer i;
  bank_remap u_bank_remap (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .flash_req, .ram_req, .mem_we, .mem_addr,
    .mem_wdata, .remapped);
  cpu_core_model u_cpu_core_model (.clk, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata);
  // Second build with the upper RAM range barred, fed the same traffic
  wire x_flash_req, x_ram_req, x_remapped;
  wire [31:0] x_mem_addr;
  bank_remap #(.FULL_VARIANT(1), .EXCLUDE_UPPER(1)) u_bank_remap_excl (.clk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .cpu_req, .cpu_we, .cpu_addr,
    .cpu_wdata, .flash_req(x_flash_req), .ram_req(x_ram_req), .mem_we(),
    .mem_addr(x_mem_addr), .mem_wdata(), .remapped(x_remapped));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [15:0] e);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
    end
  endtask
  // One access; outputs are judged once the answering edge has landed
  task acc(input logic we, input logic [31:0] a, input logic [2:0] e, input logic [31:0] ea);
    begin
      u_cpu_core_model.issue(we, a, ~a);
      #1 chk("route", {29'h0, e}, {29'h0, flash_req, ram_req, remapped});
      chk("mem_addr", ea, mem_addr);
      chk("mem_we", {31'h0, we}, {31'h0, mem_we});
      chk("mem_wdata", ~a, mem_wdata);
    end
  endtask
  task s_reset;
    for (i = 0; i < 9; i = i + 1) rd(i[3:0], 16'h0000);
  endtask
  task s_mode_gate;
    begin
      wr(4'h1, 16'h8004);
      acc(1'b0, 32'h00004010, FL, 32'h00004010);
      wr(4'h0, 16'h0001);
      acc(1'b1, 32'h00004010, RM, 32'h00804010);
      rd(4'h1, 16'h8004);
      wr(4'h1, 16'h0004);
      acc(1'b0, 32'h00004010, FL, 32'h00004010);
    end
  endtask
  // Even codes only; offset 1FFE, next to last, of each 8 Kbyte bank
  task s_large;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(i[3:0] + 4'h1, 16'h8010 + 16'(2 * i));
        acc(1'b1, 32'h00011FFE + 32'(i * 32'h2000), RM, 32'h00805FFE + 32'(i * 32'h2000));
      end
      wr(4'h4, 16'h807E);
      rd(4'h4, 16'h807E);
      acc(1'b0, 32'h0007E000, RM, 32'h0080A000);
      chk("excl_large_route", {29'h0, RM}, {29'h0, x_flash_req, x_ram_req, x_remapped});
      chk("excl_large_addr", 32'h0080A000, x_mem_addr);
      acc(1'b0, 32'h00080000, FL, 32'h00080000);
    end
  endtask
  task s_priority;
    begin
      wr(4'h1, 16'h8030);
      wr(4'h2, 16'h8030);
      wr(4'h5, 16'h8030);
      wr(4'h6, 16'h8030);
      acc(1'b0, 32'h00030004, RM, 32'h00804004);
      wr(4'h1, 16'h0030);
      acc(1'b0, 32'h00030004, RM, 32'h00806004);
      wr(4'h2, 16'h0030);
      acc(1'b1, 32'h00030004, RM, 32'h0080C004);
      chk("excl_small_route", {29'h0, FL}, {29'h0, x_flash_req, x_ram_req, x_remapped});
      chk("excl_small_addr", 32'h00030004, x_mem_addr);
      wr(4'h5, 16'h0030);
      acc(1'b0, 32'h00030FFF, RM, 32'h0080DFFF);
      rd(4'h7, 16'h000D);
      wr(4'h6, 16'h0030);
      acc(1'b0, 32'h00030004, FL, 32'h00030004);
      rd(4'h7, 16'h0000);
    end
  endtask
  task s_direct;
    begin
      acc(1'b1, 32'h00804000, RD, 32'h00804000);
      acc(1'b0, 32'h0080BFFC, RD, 32'h0080BFFC);
      // Ten remapped accesses so far; direct RAM traffic never counts
      rd(4'h8, 16'h000A);
      wr(4'h8, 16'h0000);
      rd(4'h8, 16'h0000);
    end
  endtask
  task final_report;
    begin
      if (miscompares == 0 && checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // Main sequence after a three-cycle reset
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    s_reset;
    s_mode_gate;
    s_large;
    s_priority;
    s_direct;
    final_report;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    miscompares = miscompares + 1;
    final_report;
  end
endmodule // bank_remap_bench
